// ==== hw/ust_pkg.sv ====
// Types shared by the sync transmitter.
// Assumes the register header supplies all register constants; state encodings are set here.
package ust_pkg;

  typedef enum logic [2:0] {
    UST_TX_IDLE = 3'h1,
    UST_TX_LOAD = 3'h2,
    UST_TX_SHIFT = 3'h4
  } ust_tx_state_type;

  typedef struct packed {
    logic port_en;
    logic single_rx;
    logic cont_rx;
    logic clk_src;
    logic nine_bit;
    logic tx_en;
    logic sync_mode;
    logic ninth_bit;
  } ust_ctrl_type;

endpackage

// ==== hw/ust_regs.svh ====
// Register map, field positions and reset values of the sync transmitter.
// Assumes a 32-bit APB with word-aligned registers at index times four.
`ifndef UST_REGS_SVH
`define UST_REGS_SVH

`define UST_IDX_IRQ_FLAGS 8'h0C
`define UST_IDX_RX_CTRL 8'h18
`define UST_IDX_TX_BUF 8'h19
`define UST_IDX_RX_BUF 8'h1A
`define UST_IDX_IRQ_EN 8'h8C
`define UST_IDX_TX_CTRL 8'h98
`define UST_IDX_BAUD 8'h99

`define UST_RST_IRQ_FLAGS 8'h00
`define UST_RST_RX_CTRL 8'h00
`define UST_RST_TX_BUF 8'h00
`define UST_RST_RX_BUF 8'h00
`define UST_RST_IRQ_EN 8'h00
`define UST_RST_TX_CTRL 8'h02
`define UST_RST_BAUD 8'h00

`define UST_FLG_RX_DONE 5
`define UST_FLG_TX_EMPTY 4
`define UST_RC_PORT_EN 7
`define UST_RC_SINGLE 5
`define UST_RC_CONT 4
`define UST_TC_CLK_SRC 7
`define UST_TC_NINE 6
`define UST_TC_TX_EN 5
`define UST_TC_SYNC 4
`define UST_TC_SR_EMPTY 1
`define UST_TC_NINTH 0

`define UST_BITS_8 4'h8
`define UST_BITS_9 4'h9
`define UST_ZERO_8 8'h00
`define UST_ZERO_4 4'h0
`define UST_ZERO_9 9'h000
`define UST_ONE_4 4'h1

`endif

// ==== hw/ust_sync_tx.sv ====
// Synchronous master transmitter with APB register slave.
// Assumes pclk at 250 MHz, pins brought in through three-flop sampling.
`timescale 1ns/1ps
`default_nettype none
`include "ust_regs.svh"

module ust_sync_tx (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Shift clock line
  output logic clk_line_out,
  output logic clk_line_oe_n,
  // Serial data line
  input wire logic data_line_in,
  output logic data_line_out,
  output logic data_line_oe_n
);

  ust_pkg::ust_ctrl_type ctrl_reg;
  ust_pkg::ust_tx_state_type tx_state_reg;
  ust_pkg::ust_tx_state_type tx_state_next;
  logic [7:0] tx_buf_reg;
  logic tx_buf_full_reg;
  logic tx_flag_reg;
  logic [7:0] rx_buf_reg;
  logic rx_flag_reg;
  logic [7:0] irq_en_reg;
  logic [7:0] baud_reg;
  logic [7:0] baud_cnt_reg;
  logic [8:0] shift_reg;
  logic [3:0] tx_cnt_reg;
  logic [3:0] tx_len_reg;
  logic [7:0] rx_shift_reg;
  logic [3:0] rx_cnt_reg;
  logic ck_reg;
  logic dt_out_reg;
  logic [2:0] dt_sync_reg;
  logic dt_in_reg;

  logic [7:0] index;
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  logic master_ok;
  logic rx_active;
  logic tx_owns;
  logic baud_run;
  logic tick;
  logic rise;
  logic fall;
  logic wr_tx_buf;
  logic wr_rx_ctrl;
  logic wr_tx_ctrl;
  logic tx_en_rise;
  logic load_done;
  logic word_sent;
  logic bit_done;
  logic rx_word;
  logic [7:0] rd_data;

  // Register index from byte address
  function automatic logic [7:0] word_index(input logic [11:0] addr);
    word_index = addr[9:2];
  endfunction

  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx == `UST_IDX_IRQ_FLAGS) || (idx == `UST_IDX_RX_CTRL) ||
      (idx == `UST_IDX_TX_BUF) || (idx == `UST_IDX_RX_BUF) ||
      (idx == `UST_IDX_IRQ_EN) || (idx == `UST_IDX_TX_CTRL) ||
      (idx == `UST_IDX_BAUD);
  endfunction

  assign index = word_index(paddr);
  assign mapped = is_mapped(index) && (paddr[11:10] == 2'h0);
  assign access = psel && penable;
  assign wr = access && pwrite && pstrb[0] && mapped;
  assign rd = access && !pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  assign wr_tx_buf = wr && (index == `UST_IDX_TX_BUF);
  assign wr_rx_ctrl = wr && (index == `UST_IDX_RX_CTRL);
  assign wr_tx_ctrl = wr && (index == `UST_IDX_TX_CTRL);

  // Master operation needs all three mode bits
  assign master_ok = ctrl_reg.port_en && ctrl_reg.sync_mode &&
    ctrl_reg.clk_src;
  assign rx_active = master_ok &&
    (ctrl_reg.cont_rx || ctrl_reg.single_rx);
  assign tx_owns = master_ok && ctrl_reg.tx_en && !rx_active;

  // Baud generator
  assign baud_run = ctrl_reg.tx_en || ctrl_reg.cont_rx ||
    ctrl_reg.single_rx;
  assign tick = baud_run && (baud_cnt_reg == `UST_ZERO_8);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt_reg <= `UST_ZERO_8;
    end else if (!baud_run) begin
      // Held at zero so the first tick comes at once
      baud_cnt_reg <= `UST_ZERO_8;
    end else if (tick) begin
      baud_cnt_reg <= baud_reg;
    end else begin
      baud_cnt_reg <= baud_cnt_reg - 8'h01;
    end
  end

  // Shift clock toggles only while a word moves
  assign rise = tick && !ck_reg &&
    ((tx_owns && tx_state_reg == ust_pkg::UST_TX_SHIFT) || rx_active);
  assign fall = tick && ck_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_reg <= 1'b0;
    end else if (!master_ok || !baud_run) begin
      ck_reg <= 1'b0;
    end else if (rise) begin
      ck_reg <= 1'b1;
    end else if (fall) begin
      ck_reg <= 1'b0;
    end
  end

  // Data pin sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dt_sync_reg <= 3'h7;
    end else begin
      dt_sync_reg <= {dt_sync_reg[1:0], data_line_in};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dt_in_reg <= 1'b1;
    end else if (dt_sync_reg[1] == dt_sync_reg[2]) begin
      dt_in_reg <= dt_sync_reg[2];
    end
  end

  // Transmit state machine
  assign tx_en_rise = wr_tx_ctrl && !ctrl_reg.tx_en &&
    pwdata[`UST_TC_TX_EN];
  assign load_done = tx_state_reg == ust_pkg::UST_TX_LOAD;
  // Advance at the falling edge; a receive that cuts in resends the bit
  assign bit_done = tx_owns && fall &&
    tx_state_reg == ust_pkg::UST_TX_SHIFT;
  assign word_sent = bit_done && tx_cnt_reg == (tx_len_reg - `UST_ONE_4);

  always_comb begin
    tx_state_next = tx_state_reg;
    unique case (tx_state_reg)
      ust_pkg::UST_TX_IDLE: begin
        if (tx_owns && tx_buf_full_reg) begin
          tx_state_next = ust_pkg::UST_TX_LOAD;
        end
      end
      ust_pkg::UST_TX_LOAD: begin
        tx_state_next = ust_pkg::UST_TX_SHIFT;
      end
      ust_pkg::UST_TX_SHIFT: begin
        if (word_sent) begin
          tx_state_next = ust_pkg::UST_TX_IDLE;
        end
      end
      default: begin
        tx_state_next = ust_pkg::UST_TX_IDLE;
      end
    endcase
    if (!ctrl_reg.tx_en) begin
      tx_state_next = ust_pkg::UST_TX_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg <= ust_pkg::UST_TX_IDLE;
    end else begin
      tx_state_reg <= tx_state_next;
    end
  end

  // Hidden shift register; no bus path reaches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= `UST_ZERO_9;
      tx_len_reg <= `UST_BITS_8;
    end else if (load_done) begin
      shift_reg <= {ctrl_reg.ninth_bit, tx_buf_reg};
      tx_len_reg <= ctrl_reg.nine_bit ? `UST_BITS_9 : `UST_BITS_8;
    end else if (bit_done) begin
      shift_reg <= {1'b0, shift_reg[8:1]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt_reg <= `UST_ZERO_4;
    end else if (!ctrl_reg.tx_en || load_done) begin
      tx_cnt_reg <= `UST_ZERO_4;
    end else if (bit_done) begin
      tx_cnt_reg <= tx_cnt_reg + `UST_ONE_4;
    end
  end

  // Bit changes on rising edge, so it is settled at the falling one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dt_out_reg <= 1'b0;
    end else if (!ctrl_reg.tx_en) begin
      dt_out_reg <= 1'b0;
    end else if (tx_owns && rise) begin
      dt_out_reg <= shift_reg[0];
    end
  end

  // Transmit buffer and its fill state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_reg <= `UST_RST_TX_BUF;
    end else if (wr_tx_buf) begin
      tx_buf_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_full_reg <= 1'b0;
    end else if (wr_tx_buf) begin
      tx_buf_full_reg <= 1'b1;
    end else if (load_done) begin
      tx_buf_full_reg <= 1'b0;
    end
  end

  // Empty flag: hardware sets, only a buffer write clears; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_flag_reg <= 1'b0;
    end else if (load_done || (tx_en_rise && !tx_buf_full_reg)) begin
      tx_flag_reg <= 1'b1;
    end else if (wr_tx_buf) begin
      tx_flag_reg <= 1'b0;
    end
  end

  // Master receive; takes priority and parks transmit while active
  assign rx_word = rx_active && fall &&
    rx_cnt_reg == (`UST_BITS_8 - `UST_ONE_4);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt_reg <= `UST_ZERO_4;
      rx_shift_reg <= `UST_ZERO_8;
    end else if (!rx_active || rx_word) begin
      rx_cnt_reg <= `UST_ZERO_4;
    end else if (fall) begin
      rx_cnt_reg <= rx_cnt_reg + `UST_ONE_4;
      rx_shift_reg <= {dt_in_reg, rx_shift_reg[7:1]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_reg <= `UST_RST_RX_BUF;
    end else if (rx_word) begin
      rx_buf_reg <= {dt_in_reg, rx_shift_reg[7:1]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_flag_reg <= 1'b0;
    end else if (rx_word) begin
      rx_flag_reg <= 1'b1;
    end else if (rd && index == `UST_IDX_RX_BUF) begin
      rx_flag_reg <= 1'b0;
    end
  end

  // Control bits; single receive self-clears, set by software wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '0;
    end else begin
      if (wr_rx_ctrl) begin
        ctrl_reg.port_en <= pwdata[`UST_RC_PORT_EN];
        ctrl_reg.single_rx <= pwdata[`UST_RC_SINGLE];
        ctrl_reg.cont_rx <= pwdata[`UST_RC_CONT];
      end else if (rx_word && !ctrl_reg.cont_rx) begin
        ctrl_reg.single_rx <= 1'b0;
      end
      if (wr_tx_ctrl) begin
        ctrl_reg.clk_src <= pwdata[`UST_TC_CLK_SRC];
        ctrl_reg.nine_bit <= pwdata[`UST_TC_NINE];
        ctrl_reg.tx_en <= pwdata[`UST_TC_TX_EN];
        ctrl_reg.sync_mode <= pwdata[`UST_TC_SYNC];
        ctrl_reg.ninth_bit <= pwdata[`UST_TC_NINTH];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_reg <= `UST_RST_IRQ_EN;
      baud_reg <= `UST_RST_BAUD;
    end else begin
      if (wr && index == `UST_IDX_IRQ_EN) begin
        irq_en_reg <= pwdata[7:0];
      end
      if (wr && index == `UST_IDX_BAUD) begin
        baud_reg <= pwdata[7:0];
      end
    end
  end

  // Read multiplexer
  always_comb begin
    rd_data = `UST_ZERO_8;
    case (index)
      `UST_IDX_IRQ_FLAGS: begin
        rd_data[`UST_FLG_RX_DONE] = rx_flag_reg;
        rd_data[`UST_FLG_TX_EMPTY] = tx_flag_reg;
      end
      `UST_IDX_RX_CTRL: begin
        rd_data[`UST_RC_PORT_EN] = ctrl_reg.port_en;
        rd_data[`UST_RC_SINGLE] = ctrl_reg.single_rx;
        rd_data[`UST_RC_CONT] = ctrl_reg.cont_rx;
      end
      `UST_IDX_TX_BUF: begin
        rd_data = tx_buf_reg;
      end
      `UST_IDX_RX_BUF: begin
        rd_data = rx_buf_reg;
      end
      `UST_IDX_IRQ_EN: begin
        rd_data = irq_en_reg;
      end
      `UST_IDX_TX_CTRL: begin
        rd_data[`UST_TC_CLK_SRC] = ctrl_reg.clk_src;
        rd_data[`UST_TC_NINE] = ctrl_reg.nine_bit;
        rd_data[`UST_TC_TX_EN] = ctrl_reg.tx_en;
        rd_data[`UST_TC_SYNC] = ctrl_reg.sync_mode;
        rd_data[`UST_TC_SR_EMPTY] =
          tx_state_reg == ust_pkg::UST_TX_IDLE;
        rd_data[`UST_TC_NINTH] = ctrl_reg.ninth_bit;
      end
      `UST_IDX_BAUD: begin
        rd_data = baud_reg;
      end
      default: begin
        rd_data = `UST_ZERO_8;
      end
    endcase
  end

  // Registered read data, taken in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, rd_data};
    end
  end

  // Pin drivers; enables are active low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_line_oe_n <= 1'b1;
      data_line_oe_n <= 1'b1;
    end else begin
      clk_line_oe_n <= !(master_ok &&
        (ctrl_reg.tx_en || rx_active));
      data_line_oe_n <= !tx_owns;
    end
  end

  assign clk_line_out = ck_reg;
  assign data_line_out = dt_out_reg;

endmodule
`default_nettype wire

// ==== sim/tb_ust_sync_tx.sv ====
// Self-checking bench for the sync transmitter with a slave model.
// Assumes the register header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "ust_regs.svh"
module tb_ust_sync_tx;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, clr;
  logic clk_line_out, clk_line_oe_n, data_line_in, data_line_out;
  logic data_line_oe_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, cnt;
  logic [8:0] sr;
  int fails, checked, cyc;
  ust_sync_tx dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .clk_line_out,
    .clk_line_oe_n, .data_line_in, .data_line_out, .data_line_oe_n);
  ust_slave_model slave (.clk_line_out, .clk_line_oe_n, .data_line_out,
    .data_line_oe_n, .data_line_in, .clr, .cnt, .sr);
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  task automatic test_done;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'h0, idx, 8'h00);
    chk(rd, {24'h000000, exp});
  endtask
  task automatic word(input logic [3:0] n, input logic [8:0] exp);
    for (int i = 0; i < 3000 && cnt != n; i++) @(posedge pclk);
    chk({19'h00000, cnt, sr >> (4'h9 - n)}, {19'h00000, n, exp});
    clr <= 1'h1;
    @(posedge pclk);
    clr <= 1'h0;
  endtask
  task automatic t_reset;
    logic [7:0] idx [8] = '{`UST_IDX_IRQ_FLAGS, `UST_IDX_RX_CTRL,
      `UST_IDX_TX_BUF, `UST_IDX_RX_BUF, `UST_IDX_IRQ_EN, `UST_IDX_TX_CTRL,
      `UST_IDX_BAUD, 8'h40};
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02,
      8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rdc(idx[i], rv[i]);
      chk({31'h0, err}, {31'h0, i == 7});
    end
  endtask
  task automatic t_setup;
    apb(1'h1, `UST_IDX_BAUD, 8'h05);
    apb(1'h1, `UST_IDX_RX_CTRL, 8'h80);
    apb(1'h1, `UST_IDX_TX_CTRL, 8'h90);
    apb(1'h1, `UST_IDX_TX_CTRL, 8'hB0);
    apb(1'h1, `UST_IDX_IRQ_FLAGS, 8'h00);
    rdc(`UST_IDX_IRQ_FLAGS, 8'h10);
    repeat (40) @(posedge pclk);
    chk({28'h0, cnt}, 32'h0);
  endtask
  task automatic t_b2b;
    apb(1'h1, `UST_IDX_TX_BUF, 8'hA5);
    repeat (2) @(posedge pclk);
    rdc(`UST_IDX_IRQ_FLAGS, 8'h10);
    rdc(`UST_IDX_TX_CTRL, 8'hB0);
    apb(1'h1, `UST_IDX_TX_BUF, 8'h3C);
    rdc(`UST_IDX_IRQ_FLAGS, 8'h00);
    word(4'h8, 9'h0A5);
    word(4'h8, 9'h03C);
    rdc(`UST_IDX_IRQ_FLAGS, 8'h10);
    rdc(`UST_IDX_TX_CTRL, 8'hB2);
  endtask
  task automatic t_nine;
    apb(1'h1, `UST_IDX_TX_CTRL, 8'hF1);
    apb(1'h1, `UST_IDX_TX_BUF, 8'h3C);
    repeat (2) @(posedge pclk);
    apb(1'h1, `UST_IDX_TX_CTRL, 8'hF0);
    word(4'h9, 9'h13C);
    rdc(`UST_IDX_TX_CTRL, 8'hF2);
    apb(1'h1, `UST_IDX_TX_CTRL, 8'hB0);
  endtask
  task automatic t_abort;
    logic [3:0] held;
    apb(1'h1, `UST_IDX_TX_BUF, 8'h81);
    repeat (30) @(posedge pclk);
    apb(1'h1, `UST_IDX_TX_CTRL, 8'h90);
    repeat (2) @(posedge pclk);
    chk({30'h0, clk_line_oe_n, data_line_oe_n}, 32'h3);
    rdc(`UST_IDX_TX_CTRL, 8'h92);
    held = cnt;
    repeat (100) @(posedge pclk);
    chk({28'h0, cnt}, {28'h0, held});
    clr <= 1'h1;
    @(posedge pclk);
    clr <= 1'h0;
    apb(1'h1, `UST_IDX_TX_CTRL, 8'hB0);
    apb(1'h1, `UST_IDX_TX_BUF, 8'h5A);
    word(4'h8, 9'h05A);
  endtask
  task automatic t_rx;
    apb(1'h1, `UST_IDX_TX_BUF, 8'hC3);
    repeat (30) @(posedge pclk);
    apb(1'h1, `UST_IDX_RX_CTRL, 8'h90);
    repeat (2) @(posedge pclk);
    chk({30'h0, clk_line_oe_n, data_line_oe_n}, 32'h1);
    apb(1'h1, `UST_IDX_RX_CTRL, 8'hA0);
    for (int i = 0; i < 200; i++) begin
      apb(1'h0, `UST_IDX_RX_CTRL, 8'h00);
      if (rd[5] === 1'h0)
        break;
    end
    chk(rd, 32'h80);
    chk({31'h0, data_line_oe_n}, 32'h0);
    word(4'h8, 9'h0C3);
    rdc(`UST_IDX_IRQ_FLAGS, 8'h30);
  endtask
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    clr = 1'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    t_reset;
    t_setup;
    t_b2b;
    t_nine;
    t_abort;
    t_rx;
    test_done;
  end
endmodule
`default_nettype wire

// ==== sim/ust_slave_model.sv ====
// Behavioural synchronous slave on the shift clock and data lines.
// Assumes the device is master and makes the clock itself.
`timescale 1ns/1ps
`default_nettype none
module ust_slave_model (
  // Lines from the device
  input wire logic clk_line_out,
  input wire logic clk_line_oe_n,
  input wire logic data_line_out,
  input wire logic data_line_oe_n,
  // Data pin seen by the device
  output logic data_line_in,
  // Bench side
  input wire logic clr,
  output logic [3:0] cnt,
  output logic [8:0] sr
);
  logic drv;
  // No pull on the wire, so a floated line must keep moving
  assign data_line_in = data_line_oe_n ? drv : data_line_out;
  initial begin
    drv = 1'h0;
    cnt = 4'h0;
    sr = 9'h000;
  end
  always @(posedge clk_line_out) begin
    drv = ~drv;
  end
  // Only bits the device really drives are latched
  always @(negedge clk_line_out or posedge clr) begin
    if (clr) begin
      cnt = 4'h0;
    end else begin
      // Enables may change on the same edge; judge them once settled
      #0.1;
      if (!clk_line_oe_n && !data_line_oe_n) begin
        sr = {data_line_out, sr[8:1]};
        cnt = cnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/ust_sync_tx_sva.sv ====
// Port checker for the sync transmitter, bound into every instance.
// Assumes register fields change only through APB writes.
`timescale 1ns/1ps
`default_nettype none
module ust_sync_tx_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Serial lines
  input wire logic clk_line_out,
  input wire logic clk_line_oe_n,
  input wire logic data_line_in,
  input wire logic data_line_out,
  input wire logic data_line_oe_n
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [7:0] rc_reg, tc_reg, bd_reg, hi_reg;
  logic mapped, wr, transmit_enable, sync, pen, clock_source_select, rx_on;
  always_comb begin
    case (paddr[9:2])
      8'h0C, 8'h18, 8'h19, 8'h1A, 8'h8C, 8'h98, 8'h99:
        mapped = paddr[11:10] == 2'h0;
      default:
        mapped = 1'h0;
    endcase
  end
  assign wr = psel && penable && pwrite && pstrb[0] && mapped;
  assign transmit_enable = tc_reg[5];
  assign sync = tc_reg[4];
  assign clock_source_select = tc_reg[7];
  assign pen = rc_reg[7];
  assign rx_on = rc_reg[4] && pen && clock_source_select && sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_reg <= 8'h00;
      tc_reg <= 8'h02;
      bd_reg <= 8'h00;
    end else if (wr) begin
      if (paddr[9:2] == 8'h18)
        rc_reg <= pwdata[7:0];
      if (paddr[9:2] == 8'h98)
        tc_reg <= pwdata[7:0];
      if (paddr[9:2] == 8'h99)
        bd_reg <= pwdata[7:0];
    end
  end
  // Length of the current high phase of the shift clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hi_reg <= 8'h00;
    else if (clk_line_out)
      hi_reg <= hi_reg + 8'h01;
    else
      hi_reg <= 8'h00;
  end
  unmapped_error_a: assert property (
    psel && penable && !mapped |-> pslverr)
    else $error("unmapped access gave no error");
  sync_gate_a: assert property (
    !sync && !$past(sync) |-> clk_line_oe_n && data_line_oe_n)
    else $error("lines driven outside clocked mode");
  port_gate_a: assert property (
    !pen && !$past(pen) |-> clk_line_oe_n && data_line_oe_n)
    else $error("lines driven with port disabled");
  master_gate_a: assert property (
    !clock_source_select && !$past(clock_source_select) |-> clk_line_oe_n)
    else $error("clock driven without master source");
  tx_abort_a: assert property (
    !transmit_enable && !$past(transmit_enable) |-> data_line_oe_n)
    else $error("data driven with transmit disabled");
  rx_float_a: assert property (
    rx_on && $past(rx_on) |-> data_line_oe_n && !clk_line_oe_n)
    else $error("wrong pin roles while receiving");
  half_period_a: assert property (
    $fell(clk_line_out) && !clk_line_oe_n |-> hi_reg == bd_reg + 8'h01)
    else $error("clock high phase not divisor plus one");
  data_hold_a: assert property (
    $fell(clk_line_out) && !data_line_oe_n |-> $stable(data_line_out))
    else $error("data moved at falling clock");
  idle_low_a: assert property (
    clk_line_oe_n && $past(clk_line_oe_n) |-> !clk_line_out)
    else $error("floating clock not low");
  cover property ($fell(clk_line_out) && !data_line_oe_n);
  cover property (rx_on && !clk_line_oe_n);
  cover property (psel && penable && pslverr);
endmodule
bind ust_sync_tx ust_sync_tx_sva chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .clk_line_out, .clk_line_oe_n, .data_line_in, .data_line_out,
  .data_line_oe_n);
`default_nettype wire
